// ---- rtl/flash_sec_regs.vh ----
// Opcodes, field positions, reset values and timing for the security and parameter block.
`ifndef FLASH_SEC_REGS_VH
`define FLASH_SEC_REGS_VH
`define OP_READ_TABLE      8'h5A
`define OP_SEC_ERASE       8'h44
`define OP_SEC_PROGRAM     8'h42
`define OP_SEC_READ        8'h48
`define OP_SET_PARAMS      8'hC0
`define OP_SET_WRAP        8'h77
`define OP_ENTER_QUAD      8'h38
`define OP_EXIT_QUAD       8'hFF
`define OP_WRITE_ENABLE    8'h06
`define OP_RESET_ENABLE    8'h66
`define OP_RESET_DEVICE    8'h99
`define ADDR_TOP_ZERO      8'h00
`define ADDR_MID_ZERO      4'h0
`define SEC_SEL_ONE        4'h1
`define SEC_SEL_TWO        4'h2
`define SEC_SEL_THREE      4'h3
`define BITS_OPCODE        6'h08
`define BITS_ADDRESS_END   6'h20
`define BITS_DUMMY_END     6'h28
`define ERASED_BYTE        8'hFF
`define DUMMY_FIELD_HI     5
`define DUMMY_FIELD_LO     4
`define WRAP_FIELD_HI      1
`define WRAP_FIELD_LO      0
`define SERIAL_WRAP_HI     5
`define SERIAL_WRAP_LO     4
`define DEFAULT_DUMMY_SEL  2'h0
`define DEFAULT_WRAP_SEL   2'h0
`define ERASE_TIME_US      400
`define CLOCK_MHZ          10
`endif

// ---- rtl/byte_fifo.v ----
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   // Clock and reset.
   input  wire             clock,
   input  wire             sys_rst,
   // Fill side.
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side.
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_ptr;
   reg [AW:0]      rd_ptr;
   wire            do_wr = in_valid && in_ready;
   wire            do_rd = out_valid && out_ready;
   assign in_ready  = (wr_ptr - rd_ptr) != DEPTH[AW:0];
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data  = mem[rd_ptr[AW-1:0]];
   always @(posedge clock) begin
      if (sys_rst) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
   always @(posedge clock) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule // byte_fifo
`default_nettype wire

// ---- rtl/flash_security_sfdp_readparam.v ----
// Serial flash command logic: parameter table, security registers and read parameters.
`timescale 1ns/1ps
`default_nettype none
`include "flash_sec_regs.vh"
module flash_security_sfdp_readparam #(
   parameter ERASE_CYCLES = (`ERASE_TIME_US * `CLOCK_MHZ),
   parameter FIFO_DEPTH   = 32
) (
   // Clock and reset.
   input  wire       clock,
   input  wire       sys_rst,
   // Serial pins.
   input  wire       chip_select_n,
   input  wire       serial_clock,
   input  wire       serial_data_in,
   output reg        serial_data_out,
   output reg        serial_data_oe,
   // Status.
   input  wire [2:0] otp_lock_bits,
   output reg        write_enable_latch,
   output reg        busy,
   output reg        quad_peripheral_mode,
   output reg  [1:0] dummy_count_field,
   output reg  [1:0] wrap_length_field,
   output reg  [3:0] quad_dummy_clocks,
   output reg  [6:0] wrap_length_bytes
);
   localparam ST_CMD   = 3'h0;
   localparam ST_ADDR  = 3'h1;
   localparam ST_DUMMY = 3'h2;
   localparam ST_OUT   = 3'h3;
   localparam ST_PROG  = 3'h4;
   localparam ST_PARAM = 3'h5;
   localparam ST_IDLE  = 3'h6;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: a change counts once stages two and three agree.
   reg [2:0] cs_sync;
   reg [2:0] sck_sync;
   reg [2:0] din_sync;
   reg       cs_n;
   reg       sck;
   reg       din;
   always @(posedge clock) begin
      if (sys_rst) begin
         cs_sync  <= 3'h7;
         sck_sync <= 3'h0;
         din_sync <= 3'h0;
         cs_n     <= 1'b1;
         sck      <= 1'b0;
         din      <= 1'b0;
      end else begin
         cs_sync  <= {cs_sync[1:0], chip_select_n};
         sck_sync <= {sck_sync[1:0], serial_clock};
         din_sync <= {din_sync[1:0], serial_data_in};
         if (cs_sync[1] == cs_sync[2]) begin
            cs_n <= cs_sync[2];
         end
         if (sck_sync[1] == sck_sync[2]) begin
            sck <= sck_sync[2];
         end
         if (din_sync[1] == din_sync[2]) begin
            din <= din_sync[2];
         end
      end
   end
   wire sck_rise  = (sck_sync[1] == sck_sync[2]) && sck_sync[2] && !sck;
   wire sck_fall  = (sck_sync[1] == sck_sync[2]) && !sck_sync[2] && sck;
   wire cs_rise   = (cs_sync[1] == cs_sync[2]) && cs_sync[2] && !cs_n;

   ////////////////////////////////////////////////////////////////////////////////
   // Storage: parameter table and three security registers in flip-flops.
   reg [7:0] table_mem [0:255];
   reg [7:0] sec_mem   [0:767];
   integer   k;
   initial begin
      for (k = 0; k < 256; k = k + 1) begin
         table_mem[k] = k[7:0];
      end
   end

   // Returns 1..3 for a valid security address, 0 otherwise.
   function [1:0] sec_select;
      input [23:0] a;
      begin
         sec_select = 2'h0;
         if (a[23:16] == `ADDR_TOP_ZERO && a[11:8] == `ADDR_MID_ZERO) begin
            if (a[15:12] == `SEC_SEL_ONE) begin
               sec_select = 2'h1;
            end else if (a[15:12] == `SEC_SEL_TWO) begin
               sec_select = 2'h2;
            end else if (a[15:12] == `SEC_SEL_THREE) begin
               sec_select = 2'h3;
            end
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Command shifter and sequencer.
   reg [2:0]  state;
   reg [5:0]  bit_count;
   reg [7:0]  shift_in;
   reg [7:0]  opcode;
   reg [23:0] address;
   reg [7:0]  byte_addr;
   reg [1:0]  sec_sel;
   reg [7:0]  out_byte;
   reg [2:0]  out_bit;
   reg        erase_armed;
   reg        reset_armed;
   reg [1:0]  erase_sel;
   reg [31:0] erase_count;
   // The erase sweep needs at least 256 busy cycles to reach every byte.
   wire [9:0] erase_idx  = {erase_sel - 2'h1, erase_count[7:0]};
   wire [7:0] next_shift = {shift_in[6:0], din_sync[2]};
   wire       prog_ok    = write_enable_latch && !busy &&
                           sec_select(address) != 2'h0 &&
                           !otp_lock_bits[sec_select(address) - 2'h1];

   // Program bytes pass through the FIFO; a byte that arrives while the FIFO is full is dropped.
   reg        fifo_in_valid;
   reg [17:0] fifo_in_data;
   wire       fifo_in_ready;
   wire       fifo_out_valid;
   wire [17:0] fifo_out_data;
   wire       fifo_out_ready = !busy;
   byte_fifo #(.WIDTH(18), .DEPTH(FIFO_DEPTH), .AW(5)) u_prog_fifo (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );
   wire [9:0] prog_index = {fifo_out_data[17:16] - 2'h1, fifo_out_data[15:8]};

   always @(posedge clock) begin
      if (fifo_out_valid && fifo_out_ready) begin
         sec_mem[prog_index] <= sec_mem[prog_index] & fifo_out_data[7:0];
      end else if (busy) begin
         sec_mem[erase_idx] <= `ERASED_BYTE;
      end
   end

   always @(posedge clock) begin
      if (sys_rst) begin
         state                <= ST_CMD;
         bit_count            <= 6'h00;
         shift_in             <= 8'h00;
         opcode               <= 8'h00;
         address              <= 24'h000000;
         byte_addr            <= 8'h00;
         sec_sel              <= 2'h0;
         out_byte             <= 8'h00;
         out_bit              <= 3'h7;
         erase_armed          <= 1'b0;
         reset_armed          <= 1'b0;
         erase_sel            <= 2'h0;
         erase_count          <= 32'h0;
         fifo_in_valid        <= 1'b0;
         fifo_in_data         <= 18'h00000;
         serial_data_out      <= 1'b0;
         serial_data_oe       <= 1'b0;
         write_enable_latch   <= 1'b0;
         busy                 <= 1'b0;
         quad_peripheral_mode <= 1'b0;
         dummy_count_field    <= `DEFAULT_DUMMY_SEL;
         wrap_length_field    <= `DEFAULT_WRAP_SEL;
      end else begin
         fifo_in_valid <= 1'b0;
         if (busy) begin
            if (erase_count == ERASE_CYCLES - 1) begin
               busy               <= 1'b0;
               write_enable_latch <= 1'b0;
            end
            erase_count <= erase_count + 32'h1;
         end
         if (cs_n || cs_rise) begin
            if (cs_rise && erase_armed && bit_count == `BITS_ADDRESS_END) begin
               busy        <= 1'b1;
               erase_count <= 32'h0;
            end else if (cs_rise && state == ST_PROG && bit_count == 6'h00 &&
                         opcode == `OP_SEC_PROGRAM) begin
               write_enable_latch <= 1'b0;
            end
            state          <= ST_CMD;
            bit_count      <= 6'h00;
            erase_armed    <= 1'b0;
            serial_data_oe <= 1'b0;
         end else if (sck_rise) begin
            shift_in <= next_shift;
            if (state == ST_CMD) begin
               bit_count <= bit_count + 6'h01;
               if (bit_count == `BITS_OPCODE - 6'h01) begin
                  opcode <= next_shift;
                  state  <= ST_IDLE;
                  if (next_shift != `OP_RESET_DEVICE) begin
                     reset_armed <= next_shift == `OP_RESET_ENABLE;
                  end
                  if (busy) begin
                     state <= ST_IDLE;
                  end else if (next_shift == `OP_READ_TABLE ||
                               next_shift == `OP_SEC_READ) begin
                     state <= ST_ADDR;
                  end else if (next_shift == `OP_SEC_ERASE ||
                               next_shift == `OP_SEC_PROGRAM) begin
                     state <= ST_ADDR;
                  end else if (next_shift == `OP_SET_PARAMS && quad_peripheral_mode) begin
                     state <= ST_PARAM;
                  end else if (next_shift == `OP_SET_WRAP && !quad_peripheral_mode) begin
                     state <= ST_PARAM;
                  end else if (next_shift == `OP_WRITE_ENABLE) begin
                     write_enable_latch <= 1'b1;
                  end else if (next_shift == `OP_ENTER_QUAD) begin
                     quad_peripheral_mode <= 1'b1;
                  end else if (next_shift == `OP_EXIT_QUAD) begin
                     quad_peripheral_mode <= 1'b0;
                  end else if (next_shift == `OP_RESET_DEVICE && reset_armed) begin
                     write_enable_latch <= 1'b0;
                     dummy_count_field  <= `DEFAULT_DUMMY_SEL;
                     wrap_length_field  <= `DEFAULT_WRAP_SEL;
                     reset_armed        <= 1'b0;
                  end
               end
            end else if (state == ST_ADDR) begin
               bit_count <= bit_count + 6'h01;
               address   <= {address[22:0], din_sync[2]};
               if (bit_count == `BITS_ADDRESS_END - 6'h01) begin
                  byte_addr <= next_shift;
                  sec_sel   <= sec_select({address[22:0], din_sync[2]});
                  if (opcode == `OP_SEC_ERASE) begin
                     erase_sel   <= sec_select({address[22:0], din_sync[2]});
                     erase_armed <= write_enable_latch &&
                        sec_select({address[22:0], din_sync[2]}) != 2'h0 &&
                        !otp_lock_bits[sec_select({address[22:0], din_sync[2]}) - 2'h1];
                     state <= ST_IDLE;
                  end else if (opcode == `OP_SEC_PROGRAM) begin
                     state     <= ST_PROG;
                     bit_count <= 6'h00;
                  end else begin
                     state <= ST_DUMMY;
                  end
               end
            end else if (state == ST_DUMMY) begin
               bit_count <= bit_count + 6'h01;
               if (bit_count == `BITS_DUMMY_END - 6'h01) begin
                  state   <= ST_OUT;
                  out_bit <= 3'h7;
                  if (opcode == `OP_READ_TABLE) begin
                     out_byte <= table_mem[byte_addr];
                  end else if (sec_sel != 2'h0) begin
                     out_byte <= sec_mem[{sec_sel - 2'h1, byte_addr}];
                  end else begin
                     out_byte <= `ERASED_BYTE;
                  end
                  byte_addr <= byte_addr + 8'h01;
               end
            end else if (state == ST_PROG) begin
               bit_count <= bit_count + 6'h01;
               if (bit_count == `BITS_OPCODE - 6'h01) begin
                  bit_count <= 6'h00;
                  if (prog_ok && fifo_in_ready) begin
                     fifo_in_valid <= 1'b1;
                     fifo_in_data  <= {sec_select(address), byte_addr, next_shift};
                  end
                  byte_addr <= byte_addr + 8'h01;
               end
            end else if (state == ST_PARAM) begin
               bit_count <= bit_count + 6'h01;
               if (bit_count == `BITS_OPCODE + `BITS_OPCODE - 6'h01) begin
                  state <= ST_IDLE;
                  if (opcode == `OP_SET_PARAMS) begin
                     dummy_count_field <= next_shift[`DUMMY_FIELD_HI:`DUMMY_FIELD_LO];
                     wrap_length_field <= next_shift[`WRAP_FIELD_HI:`WRAP_FIELD_LO];
                  end else begin
                     wrap_length_field <= next_shift[`SERIAL_WRAP_HI:`SERIAL_WRAP_LO];
                  end
               end
            end else if (state == ST_IDLE) begin
               // Any clock past the last address bit spoils a pending erase.
               erase_armed <= 1'b0;
            end
         end else if (sck_fall && state == ST_OUT) begin
            serial_data_oe  <= 1'b1;
            serial_data_out <= out_byte[out_bit];
            out_bit         <= out_bit - 3'h1;
            if (out_bit == 3'h0) begin
               if (opcode == `OP_READ_TABLE) begin
                  out_byte <= table_mem[byte_addr];
               end else if (sec_sel != 2'h0) begin
                  out_byte <= sec_mem[{sec_sel - 2'h1, byte_addr}];
               end else begin
                  out_byte <= `ERASED_BYTE;
               end
               byte_addr <= byte_addr + 8'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Decoded parameter outputs, registered.
   always @(posedge clock) begin
      if (sys_rst) begin
         quad_dummy_clocks <= 4'h2;
         wrap_length_bytes <= 7'h08;
      end else begin
         quad_dummy_clocks <= {1'b0, dummy_count_field, 1'b0} + 4'h2;
         wrap_length_bytes <= 7'h08 << wrap_length_field;
      end
   end
endmodule // flash_security_sfdp_readparam
`default_nettype wire

// ---- testbench/flash_sec_properties.sv ----
// Concurrent checks on the ports of the security register and read parameter block.
`timescale 1ns/1ps
`default_nettype none
module flash_sec_properties #(
   parameter ERASE_CYCLES = 4000
) (
   // Clock and reset.
   input wire logic       clock,
   input wire logic       sys_rst,
   // Serial pins.
   input wire logic       chip_select_n,
   input wire logic       serial_data_oe,
   // Status.
   input wire logic       write_enable_latch,
   input wire logic       busy,
   input wire logic       quad_peripheral_mode,
   input wire logic [1:0] dummy_count_field,
   input wire logic [1:0] wrap_length_field,
   input wire logic [3:0] quad_dummy_clocks,
   input wire logic [6:0] wrap_length_bytes
);
   int busy_len;

   // Counts how long the current erase has kept the block busy.
   always @(posedge clock) begin
      if (sys_rst || !busy)
         busy_len <= 0;
      else
         busy_len <= busy_len + 1;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   chk_reset_defaults: assert property ($fell(sys_rst) |->
      quad_dummy_clocks == 4'h2 && wrap_length_bytes == 7'h08 && !busy && !write_enable_latch)
      else $error("outputs after reset differ from defaults");
   chk_dummy_map: assert property ($stable(dummy_count_field) [*2] |->
      quad_dummy_clocks == {1'b0, dummy_count_field, 1'b0} + 4'h2)
      else $error("dummy clock count does not match its field");
   chk_wrap_map: assert property ($stable(wrap_length_field) [*2] |->
      wrap_length_bytes == (7'h08 << wrap_length_field))
      else $error("wrap length does not match its field");
   chk_busy_min: assert property ($rose(busy) |-> busy [*8])
      else $error("busy dropped too early");
   chk_busy_bounded: assert property (busy |-> busy_len <= ERASE_CYCLES + 8)
      else $error("busy held too long");
   chk_latch_clear: assert property ($fell(busy) |-> ##[0:2] !write_enable_latch)
      else $error("latch still set after erase");
   chk_busy_needs_latch: assert property ($rose(busy) |-> $past(write_enable_latch))
      else $error("erase started without latch");
   chk_busy_after_select: assert property ($rose(busy) |-> chip_select_n)
      else $error("erase started while selected");
   chk_oe_idle: assert property (chip_select_n [*8] |-> !serial_data_oe)
      else $error("data out driven while deselected");
   chk_params_serial: assert property (
      $changed(dummy_count_field) && !quad_peripheral_mode |-> dummy_count_field == 2'h0)
      else $error("dummy field set in serial mode");

   cover property ($rose(busy));
   cover property ($rose(quad_peripheral_mode));
   cover property ($rose(serial_data_oe));
endmodule // flash_sec_properties

bind flash_security_sfdp_readparam flash_sec_properties #(
   .ERASE_CYCLES(ERASE_CYCLES)
) i_flash_sec_properties (
   .clock(clock),
   .sys_rst(sys_rst),
   .chip_select_n(chip_select_n),
   .serial_data_oe(serial_data_oe),
   .write_enable_latch(write_enable_latch),
   .busy(busy),
   .quad_peripheral_mode(quad_peripheral_mode),
   .dummy_count_field(dummy_count_field),
   .wrap_length_field(wrap_length_field),
   .quad_dummy_clocks(quad_dummy_clocks),
   .wrap_length_bytes(wrap_length_bytes)
);
`default_nettype wire

// ---- testbench/flash_host_model.sv ----
// Host controller model that drives select, serial clock and data in.
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
   // Pacing clock.
   input  wire logic clock,
   // Serial pins.
   output var  logic chip_select_n,
   output var  logic serial_clock,
   output var  logic serial_data_in,
   input  wire logic serial_data_out
);
   initial begin
      chip_select_n  = 1'b1;
      serial_clock   = 1'b0;
      serial_data_in = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // Select stays low for the whole frame; the clock rests low outside frames.
   task automatic frame_start;
      chip_select_n = 1'b0;
      tick(4);
   endtask

   // The released data line is parked on the inverse of its last bit.
   task automatic frame_end;
      tick(4);
      chip_select_n  = 1'b1;
      serial_data_in = ~serial_data_in;
      tick(8);
   endtask

   // One byte each way at 800 ns per bit; read data is taken mid high phase.
   task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         serial_data_in = tx[i];
         tick(4);
         serial_clock = 1'b1;
         tick(2);
         rx[i] = serial_data_out;
         tick(2);
         serial_clock = 1'b0;
      end
   endtask
endmodule // flash_host_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the security register and read parameter block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       clock = 1'b0;
   logic       sys_rst = 1'b1;
   logic [2:0] otp_lock_bits = 3'h0;
   wire        chip_select_n, serial_clock, serial_data_in, serial_data_out, serial_data_oe;
   wire        write_enable_latch, busy, quad_peripheral_mode;
   wire  [1:0] dummy_count_field, wrap_length_field;
   wire  [3:0] quad_dummy_clocks;
   wire  [6:0] wrap_length_bytes;
   int         miscompares = 0;
   int         checks = 0;
   logic [7:0] rx;

   always #50 clock = ~clock;

   flash_host_model i_flash_host_model (
      .clock(clock), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

   flash_security_sfdp_readparam #(.ERASE_CYCLES(300), .FIFO_DEPTH(32))
   i_flash_security_sfdp_readparam (
      .clock(clock), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
      .serial_clock(serial_clock), .serial_data_in(serial_data_in),
      .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
      .otp_lock_bits(otp_lock_bits), .write_enable_latch(write_enable_latch), .busy(busy),
      .quad_peripheral_mode(quad_peripheral_mode), .dummy_count_field(dummy_count_field),
      .wrap_length_field(wrap_length_field), .quad_dummy_clocks(quad_dummy_clocks),
      .wrap_length_bytes(wrap_length_bytes));

   task automatic compare(input logic [7:0] seen, input logic [7:0] want);
      checks++;
      if (seen !== want) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic conclude;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Sends the lowest n bytes of w, first byte highest, in one frame.
   task automatic frame(input int n, input logic [47:0] w);
      i_flash_host_model.frame_start();
      for (int k = n - 1; k >= 0; k--) begin
         i_flash_host_model.shift(w[8*k +: 8], rx);
      end
      i_flash_host_model.frame_end();
   endtask

   // Opcode, address and eight dummy clocks, then three bytes are read.
   task automatic read3(input logic [31:0] w, input logic [7:0] e0, e1, e2);
      i_flash_host_model.frame_start();
      for (int k = 4; k >= 0; k--) begin
         i_flash_host_model.shift((k == 0) ? 8'h00 : w[8*k-8 +: 8], rx);
      end
      i_flash_host_model.shift(8'h00, rx);
      compare(rx, e0);
      compare(serial_data_oe, 8'h01);
      i_flash_host_model.shift(8'h00, rx);
      compare(rx, e1);
      i_flash_host_model.shift(8'h00, rx);
      compare(rx, e2);
      i_flash_host_model.frame_end();
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 400) begin
         i_flash_host_model.tick(1);
         n++;
      end
      if (n >= 400) begin
         miscompares++;
         conclude();
      end
   endtask

   task automatic t_defaults;
      compare(quad_dummy_clocks, 8'h02);
      compare(wrap_length_bytes, 8'h08);
      compare({busy, write_enable_latch, quad_peripheral_mode}, 8'h00);
   endtask

   task automatic t_table_and_serial_param;
      read3(32'h5A000010, 8'h10, 8'h11, 8'h12);
      frame(2, 48'hC033);
      compare({dummy_count_field, quad_dummy_clocks}, 8'h02);
   endtask

   task automatic t_erase;
      frame(4, 48'h44001000);
      compare(busy, 8'h00);
      frame(1, 48'h06);
      compare(write_enable_latch, 8'h01);
      frame(4, 48'h44001000);
      compare(busy, 8'h01);
      wait_idle();
      compare(write_enable_latch, 8'h00);
      frame(1, 48'h06);
      frame(5, 48'h4400100000);
      compare({busy, write_enable_latch}, 8'h01);
   endtask

   task automatic t_program_read;
      frame(6, 48'h420010FEA53C);
      read3(32'h480010FE, 8'hA5, 8'h3C, 8'hFF);
   endtask

   task automatic t_lock;
      otp_lock_bits = 3'h2;
      frame(1, 48'h06);
      frame(4, 48'h44002000);
      compare(busy, 8'h00);
      frame(4, 48'h44003000);
      compare(busy, 8'h01);
      wait_idle();
   endtask

   task automatic t_quad_params;
      frame(2, 48'h7710);
      frame(1, 48'h38);
      compare({quad_peripheral_mode, wrap_length_bytes}, 8'h90);
      for (int i = 0; i < 4; i++) begin
         frame(2, {32'h0, 8'hC0, 2'b00, i[1:0], 2'b00, i[1:0]});
         compare(quad_dummy_clocks, 8'(2 + 2 * i));
         compare(wrap_length_bytes, 8'(8 << i));
      end
      frame(1, 48'h06);
      frame(1, 48'h66);
      frame(1, 48'h99);
      wait_idle();
      compare({write_enable_latch, dummy_count_field, wrap_length_field}, 8'h00);
      compare({quad_dummy_clocks, wrap_length_bytes[3:0]}, 8'h28);
   endtask

   initial begin
      repeat (20) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      i_flash_host_model.tick(4);
      t_defaults();
      t_table_and_serial_param();
      t_erase();
      t_program_read();
      t_lock();
      t_quad_params();
      conclude();
   end
endmodule // testbench
`default_nettype wire
